// ===== charger_event_pkg.sv
package charger_event_pkg;

  // Register byte addresses on the serial port
  localparam logic [7:0] STATUS_ADDR     = 8'h78;
  localparam logic [7:0] IRQ_EN_ADDR     = 8'h79;
  localparam logic [7:0] STATE_INFO_ADDR = 8'h7A;
  localparam logic [7:0] TIMER_CFG_ADDR  = 8'h7B;

  // Event status register bit positions
  localparam int ST_FLAG_LSB    = 4;
  localparam int ST_TIMEOUT     = 3;
  localparam int ST_TEMP_OK     = 2;
  localparam int ST_INPUT_VALID = 1;
  localparam int ST_EOC         = 0;

  // Sticky flag vector, maps onto status bits 7:4
  localparam int FLAG_CHG   = 0;
  localparam int FLAG_INPUT = 1;
  localparam int FLAG_TEMP  = 2;
  localparam int FLAG_TIMER = 3;

  // Interrupt enable register bit positions
  localparam int EN_TOTAL      = 7;
  localparam int EN_TEMP_RET   = 6;
  localparam int EN_CONNECT    = 5;
  localparam int EN_EOC_IN     = 4;
  localparam int EN_PRECOND    = 3;
  localparam int EN_TEMP_LEAVE = 2;
  localparam int EN_DISCONNECT = 1;
  localparam int EN_EOC_OUT    = 0;

  // State info and timer configuration field positions
  localparam int INFO_PHASE_LSB  = 4;
  localparam int INFO_ADAPTER    = 1;
  localparam int CFG_PRE_SEL_LSB = 0;
  localparam int CFG_TOT_SEL_LSB = 2;
  localparam int CFG_OVP_SEL_LSB = 4;

  // Values after reset
  localparam logic [7:0] IRQ_EN_RESET    = 8'h00;
  localparam logic [7:0] TIMER_CFG_RESET = 8'h00;

  // Charge phase codes and the disabled timer selector
  localparam logic [1:0] PHASE_PRECOND = 2'h0;
  localparam logic [1:0] PHASE_FAST    = 2'h1;
  localparam logic [1:0] PHASE_EOC     = 2'h2;
  localparam logic [1:0] SEL_DISABLED  = 2'h3;

  // Synchroniser bit positions
  localparam int SYN_UVLO    = 0;
  localparam int SYN_OVP     = 1;
  localparam int SYN_RESUME  = 2;
  localparam int SYN_ADAPTER = 3;
  localparam int SYN_TEMP    = 4;
  localparam int SYN_THERMAL = 5;

  // Timing: one timer unit is one second of full-current charge
  localparam int CLOCK_MHZ   = 125;
  localparam int TICK_S      = 1;
  localparam int SEC_PER_MIN = 60;
  localparam int SEC_PER_HR  = 3600;
  localparam logic [15:0] PRE_LIMIT_0 = 16'(40 * SEC_PER_MIN);
  localparam logic [15:0] PRE_LIMIT_1 = 16'(60 * SEC_PER_MIN);
  localparam logic [15:0] PRE_LIMIT_2 = 16'(80 * SEC_PER_MIN);
  localparam logic [15:0] TOT_LIMIT_0 = 16'(3 * SEC_PER_HR);
  localparam logic [15:0] TOT_LIMIT_1 = 16'(4 * SEC_PER_HR);
  localparam logic [15:0] TOT_LIMIT_2 = 16'(5 * SEC_PER_HR);
  localparam logic [4:0]  CURRENT_FULL = 5'h10;

  // Serial port states
  typedef enum logic [2:0] {
    PORT_IDLE,
    PORT_RECV,
    PORT_ACK,
    PORT_SEND,
    PORT_SACK
  } port_state_t;

endpackage : charger_event_pkg

// ===== serial_reg_port.sv
`timescale 1ns/1ps
module serial_reg_port
  import charger_event_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h2A  // Arbitrary value
)(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // Serial pins, already synchronised
  input  wire logic       scl_s,
  input  wire logic       sda_s,
  output logic            sda_oe,
  // Register side
  output logic            wr_en,
  output logic            rd_en,
  output logic [7:0]      reg_addr,
  output logic [7:0]      wr_data,
  input  wire logic [7:0] rd_data
);

  port_state_t state, next_state;
  logic [7:0] shift, next_shift, tx, next_tx, next_reg_addr;
  logic [3:0] cnt, next_cnt;
  logic       scl_q, sda_q, is_addr, next_is_addr, have_ptr, next_have_ptr;
  logic       rnw, next_rnw, byte_done, next_byte_done, nack, next_nack;
  logic       next_sda_oe, next_wr_en, next_rd_en;
  logic       start, stop, scl_rise, scl_fall;

  // Bus conditions seen on the synchronised pins
  assign start    = scl_s & scl_q & sda_q & ~sda_s;
  assign stop     = scl_s & scl_q & ~sda_q & sda_s;
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign wr_data  = shift;

  // Byte engine; pointer steps after each access
  always_comb
  begin
    next_state     = state;
    next_shift     = shift;
    next_tx        = tx;
    next_cnt       = cnt;
    next_is_addr   = is_addr;
    next_have_ptr  = have_ptr;
    next_rnw       = rnw;
    next_byte_done = byte_done;
    next_nack      = nack;
    next_sda_oe    = sda_oe;
    next_reg_addr  = reg_addr;
    next_wr_en     = 1'b0;
    next_rd_en     = 1'b0;
    if (wr_en)
      next_reg_addr = reg_addr + 8'h01;
    if (rd_en)
    begin
      // Read data is sampled here, so flags clear only when really sent
      next_tx       = rd_data;
      next_sda_oe   = ~rd_data[7];
      next_reg_addr = reg_addr + 8'h01;
    end
    if (start)
    begin
      next_state     = PORT_RECV;
      next_is_addr   = 1'b1;
      next_have_ptr  = 1'b0;
      next_cnt       = 4'h0;
      next_byte_done = 1'b0;
      next_sda_oe    = 1'b0;
    end
    else if (stop)
    begin
      next_state  = PORT_IDLE;
      next_sda_oe = 1'b0;
    end
    else
    begin
      case (state)
        PORT_IDLE: ;
        PORT_RECV:
        begin
          if (scl_rise)
          begin
            next_shift = {shift[6:0], sda_s};
            next_cnt   = cnt + 4'h1;
            if (cnt == 4'h7)
              next_byte_done = 1'b1;
          end
          if (scl_fall && byte_done)
          begin
            next_byte_done = 1'b0;
            next_cnt       = 4'h0;
            next_state     = PORT_ACK;
            next_sda_oe    = 1'b1;
            if (is_addr)
            begin
              next_is_addr = 1'b0;
              next_rnw     = shift[0];
              if (shift[7:1] != SLAVE_ADDR)
              begin
                next_state  = PORT_IDLE;
                next_sda_oe = 1'b0;
              end
            end
            else if (!have_ptr)
            begin
              next_reg_addr = shift;
              next_have_ptr = 1'b1;
            end
            else
              next_wr_en = 1'b1;
          end
        end
        PORT_ACK:
          if (scl_fall)
          begin
            next_sda_oe = 1'b0;
            next_state  = rnw ? PORT_SEND : PORT_RECV;
            next_rd_en  = rnw;
          end
        PORT_SEND:
        begin
          if (scl_rise)
            next_cnt = cnt + 4'h1;
          if (scl_fall)
          begin
            if (cnt == 4'h8)
            begin
              next_sda_oe = 1'b0;
              next_state  = PORT_SACK;
              next_cnt    = 4'h0;
            end
            else
            begin
              next_tx     = {tx[6:0], 1'b0};
              next_sda_oe = ~tx[6];
            end
          end
        end
        PORT_SACK:
        begin
          if (scl_rise)
            next_nack = sda_s;
          if (scl_fall)
          begin
            next_state = nack ? PORT_IDLE : PORT_SEND;
            next_rd_en = ~nack;
          end
        end
        default: next_state = PORT_IDLE;
      endcase
    end
  end

  // Port registers
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state     <= PORT_IDLE;
      shift     <= 8'h00;
      tx        <= 8'h00;
      cnt       <= 4'h0;
      is_addr   <= 1'b0;
      have_ptr  <= 1'b0;
      rnw       <= 1'b0;
      byte_done <= 1'b0;
      nack      <= 1'b0;
      sda_oe    <= 1'b0;
      reg_addr  <= 8'h00;
      wr_en     <= 1'b0;
      rd_en     <= 1'b0;
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
    end
    else
    begin
      state     <= next_state;
      shift     <= next_shift;
      tx        <= next_tx;
      cnt       <= next_cnt;
      is_addr   <= next_is_addr;
      have_ptr  <= next_have_ptr;
      rnw       <= next_rnw;
      byte_done <= next_byte_done;
      nack      <= next_nack;
      sda_oe    <= next_sda_oe;
      reg_addr  <= next_reg_addr;
      wr_en     <= next_wr_en;
      rd_en     <= next_rd_en;
      scl_q     <= scl_s;
      sda_q     <= sda_s;
    end
  end

endmodule : serial_reg_port

// ===== charger_event_status_logic.sv
`timescale 1ns/1ps
// Function
// - Supply connect with enable sets input flag
// - Supply disconnect with enable sets input flag
// - Input valid reads supply within thresholds
// - Input flag pends, clears when read
// - Adapter present bit follows sense comparator
// - End-of-charge entry with enable sets flag
// - End-of-charge exit with enable sets flag
// - End-of-charge bit reads charger in EOC
// - Charge-state flag pends, clears when read
// - Two-bit charge phase readable any time
// - Temperature leaving range sets temperature flag
// - Temperature returning to range sets flag
// - Temperature status reads one inside range
// - Temperature flag pends, clears when read
// - Precondition timer expiry sets timer flag
// - Total timer expiry sets timer flag
// - Timeout status reads one after expiry
// - Timer flag pends, clears when read
// - Precondition period 40/60/80 min or off
// - Total period 3/4/5 hours or off
// - Timers stretch with thermally reduced current
// - Stop charge above OVP, resume below 6V
// - Interrupt output active low until read
module charger_event_status_logic
  import charger_event_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_S * CLOCK_MHZ * 1_000_000
)(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // Serial register port
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Analog comparators, asynchronous
  input  wire logic       supply_above_uvlo,
  input  wire logic       supply_over_ovp,
  input  wire logic       supply_below_resume,
  input  wire logic       adapter_sense_input,
  input  wire logic       battery_temp_in_range,
  input  wire logic       thermal_reg_active,
  // Charger state machine, same clock
  input  wire logic [1:0] charge_phase,
  input  wire logic [4:0] charge_current_frac,
  // Outputs
  output logic            interrupt_request_n,
  output logic            charge_enable,
  output logic [1:0]      overvoltage_level_sel,
  output logic            charge_timeout
);

  logic [7:0] pin_meta, pin_sync;
  logic [5:0] in_meta, in_sync;
  logic       input_valid, wall_adapter_present, battery_temp_ok;
  logic       at_end_of_charge, thermal;
  logic       wr_en, rd_en, status_read;
  logic [7:0] reg_addr, wr_data, rd_data, status_byte, info_byte;
  logic [7:0] irq_enable, next_irq_enable, timer_cfg, next_timer_cfg;
  logic [3:0] flags, next_flags, set_vec;
  logic       valid_q, eoc_q, temp_q, timeout_occurred, next_timeout;
  logic       next_charge_enable, next_irq_n;
  logic [31:0] tick_cnt, next_tick_cnt;
  logic [4:0]  acc, next_acc, step;
  logic [5:0]  sum;
  logic [15:0] pre_cnt, next_pre_cnt, tot_cnt, next_tot_cnt;
  logic        pre_done, next_pre_done, tot_done, next_tot_done;
  logic        pre_expire, next_pre_expire, tot_expire, next_tot_expire;
  logic        tick, unit, pre_run, tot_run;
  logic [1:0]  pre_sel, tot_sel;

  // Period tables per selector code
  function automatic logic [15:0] pre_limit(input logic [1:0] sel);
    case (sel)
      2'h0:    pre_limit = PRE_LIMIT_0;
      2'h1:    pre_limit = PRE_LIMIT_1;
      default: pre_limit = PRE_LIMIT_2;
    endcase
  endfunction : pre_limit

  function automatic logic [15:0] tot_limit(input logic [1:0] sel);
    case (sel)
      2'h0:    tot_limit = TOT_LIMIT_0;
      2'h1:    tot_limit = TOT_LIMIT_1;
      default: tot_limit = TOT_LIMIT_2;
    endcase
  endfunction : tot_limit

  // Two-flop synchronisers for pins and comparators
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      pin_meta <= 8'h03;
      pin_sync <= 8'h03;
      in_meta  <= 6'h00;
      in_sync  <= 6'h00;
    end
    else
    begin
      pin_meta <= {6'h00, sda_in, scl_in};
      pin_sync <= pin_meta;
      in_meta  <= {thermal_reg_active, battery_temp_in_range,
                   adapter_sense_input, supply_below_resume,
                   supply_over_ovp, supply_above_uvlo};
      in_sync  <= in_meta;
    end
  end

  // Live status
  assign input_valid          = in_sync[SYN_UVLO] & ~in_sync[SYN_OVP];
  assign wall_adapter_present = in_sync[SYN_ADAPTER];
  assign battery_temp_ok      = in_sync[SYN_TEMP];
  assign thermal              = in_sync[SYN_THERMAL];
  assign at_end_of_charge     = (charge_phase == PHASE_EOC);
  assign sda_out              = 1'b0;

  serial_reg_port u_port (
    .clock    (clock),
    .reset    (reset),
    .scl_s    (pin_sync[0]),
    .sda_s    (pin_sync[1]),
    .sda_oe   (sda_oe),
    .wr_en    (wr_en),
    .rd_en    (rd_en),
    .reg_addr (reg_addr),
    .wr_data  (wr_data),
    .rd_data  (rd_data)
  );

  // Read-back; unmapped addresses read zero
  assign status_byte = {flags, timeout_occurred, battery_temp_ok,
                        input_valid, at_end_of_charge};
  assign info_byte   = {2'b00, charge_phase, 2'b00,
                        wall_adapter_present, 1'b0};
  assign status_read = rd_en && (reg_addr == STATUS_ADDR);
  always_comb
  begin
    case (reg_addr)
      STATUS_ADDR:     rd_data = status_byte;
      IRQ_EN_ADDR:     rd_data = irq_enable;
      STATE_INFO_ADDR: rd_data = info_byte;
      TIMER_CFG_ADDR:  rd_data = timer_cfg;
      default:         rd_data = 8'h00;
    endcase
  end

  // Events, sticky flags, configuration and OVP cutoff
  always_comb
  begin
    set_vec[FLAG_INPUT] =
      (input_valid & ~valid_q & irq_enable[EN_CONNECT]) |
      (~input_valid & valid_q & irq_enable[EN_DISCONNECT]);
    set_vec[FLAG_CHG] =
      (at_end_of_charge & ~eoc_q & irq_enable[EN_EOC_IN]) |
      (~at_end_of_charge & eoc_q & irq_enable[EN_EOC_OUT]);
    set_vec[FLAG_TEMP] =
      (~battery_temp_ok & temp_q & irq_enable[EN_TEMP_LEAVE]) |
      (battery_temp_ok & ~temp_q & irq_enable[EN_TEMP_RET]);
    set_vec[FLAG_TIMER] =
      (pre_expire & irq_enable[EN_PRECOND]) |
      (tot_expire & irq_enable[EN_TOTAL]);
    // Set wins over the clear-on-read so no event is lost
    next_flags = (flags & ~{4{status_read}}) | set_vec;
    next_irq_enable = irq_enable;
    next_timer_cfg  = timer_cfg;
    if (wr_en && reg_addr == IRQ_EN_ADDR)
      next_irq_enable = wr_data;
    if (wr_en && reg_addr == TIMER_CFG_ADDR)
      next_timer_cfg = {2'b00, wr_data[5:0]};
    // Timeout sticks for the charge cycle, ends with the supply
    next_timeout = (timeout_occurred & input_valid) | pre_expire
                   | tot_expire;
    next_charge_enable = charge_enable;
    if (in_sync[SYN_OVP])
      next_charge_enable = 1'b0;
    else if (in_sync[SYN_RESUME])
      next_charge_enable = 1'b1;
    next_irq_n = ~|next_flags;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      flags                 <= 4'h0;
      irq_enable            <= IRQ_EN_RESET;
      timer_cfg             <= TIMER_CFG_RESET;
      valid_q               <= 1'b0;
      eoc_q                 <= 1'b0;
      temp_q                <= 1'b0;
      timeout_occurred      <= 1'b0;
      charge_timeout        <= 1'b0;
      charge_enable         <= 1'b0;
      interrupt_request_n   <= 1'b1;
      overvoltage_level_sel <= TIMER_CFG_RESET[CFG_OVP_SEL_LSB +: 2];
    end
    else
    begin
      flags                 <= next_flags;
      irq_enable            <= next_irq_enable;
      timer_cfg             <= next_timer_cfg;
      valid_q               <= input_valid;
      eoc_q                 <= at_end_of_charge;
      temp_q                <= battery_temp_ok;
      timeout_occurred      <= next_timeout;
      charge_timeout        <= next_timeout;
      charge_enable         <= next_charge_enable;
      interrupt_request_n   <= next_irq_n;
      overvoltage_level_sel <= next_timer_cfg[CFG_OVP_SEL_LSB +: 2];
    end
  end

  // Safety timers; a unit is a second at full current, so reduced
  // current in thermal regulation stretches the real period in proportion
  assign pre_sel = timer_cfg[CFG_PRE_SEL_LSB +: 2];
  assign tot_sel = timer_cfg[CFG_TOT_SEL_LSB +: 2];
  assign tick    = (tick_cnt == TICK_CYCLES - 1);
  assign step    = (thermal && charge_current_frac < CURRENT_FULL)
                   ? charge_current_frac : CURRENT_FULL;
  assign sum     = {1'b0, acc} + {1'b0, step};
  assign unit    = tick && (sum >= {1'b0, CURRENT_FULL});
  assign pre_run = input_valid && charge_enable && !pre_done
                   && charge_phase == PHASE_PRECOND
                   && pre_sel != SEL_DISABLED;
  assign tot_run = input_valid && charge_enable && !tot_done
                   && (charge_phase == PHASE_PRECOND
                       || charge_phase == PHASE_FAST)
                   && tot_sel != SEL_DISABLED;

  always_comb
  begin
    next_tick_cnt   = tick ? 32'h0 : tick_cnt + 32'h1;
    next_acc        = acc;
    next_pre_cnt    = pre_cnt;
    next_tot_cnt    = tot_cnt;
    next_pre_done   = pre_done;
    next_tot_done   = tot_done;
    next_pre_expire = 1'b0;
    next_tot_expire = 1'b0;
    if (tick)
      next_acc = unit ? sum[4:0] - CURRENT_FULL : sum[4:0];
    if (unit && pre_run)
    begin
      next_pre_cnt = pre_cnt + 16'h1;
      if (next_pre_cnt >= pre_limit(pre_sel))
      begin
        next_pre_expire = 1'b1;
        next_pre_done   = 1'b1;
      end
    end
    if (unit && tot_run)
    begin
      next_tot_cnt = tot_cnt + 16'h1;
      if (next_tot_cnt >= tot_limit(tot_sel))
      begin
        next_tot_expire = 1'b1;
        next_tot_done   = 1'b1;
      end
    end
    // Leaving precondition restarts it; losing supply restarts both
    if (charge_phase != PHASE_PRECOND || !input_valid)
    begin
      next_pre_cnt  = 16'h0;
      next_pre_done = 1'b0;
    end
    if (!input_valid)
    begin
      next_tot_cnt  = 16'h0;
      next_tot_done = 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      tick_cnt   <= 32'h0;
      acc        <= 5'h00;
      pre_cnt    <= 16'h0;
      tot_cnt    <= 16'h0;
      pre_done   <= 1'b0;
      tot_done   <= 1'b0;
      pre_expire <= 1'b0;
      tot_expire <= 1'b0;
    end
    else
    begin
      tick_cnt   <= next_tick_cnt;
      acc        <= next_acc;
      pre_cnt    <= next_pre_cnt;
      tot_cnt    <= next_tot_cnt;
      pre_done   <= next_pre_done;
      tot_done   <= next_tot_done;
      pre_expire <= next_pre_expire;
      tot_expire <= next_tot_expire;
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence status_read_s;
    rd_en && reg_addr == STATUS_ADDR;
  endsequence
  sequence ovp_seen_s;
    in_sync[SYN_OVP] ##1 !in_sync[SYN_RESUME];
  endsequence

  connect_flag_a: assert property (
    input_valid && !valid_q && irq_enable[EN_CONNECT] |=> flags[FLAG_INPUT]
  ) else $error("connect event did not set input flag");
  disconnect_flag_a: assert property (
    !input_valid && valid_q && irq_enable[EN_DISCONNECT]
    |=> flags[FLAG_INPUT] ##1 !interrupt_request_n
  ) else $error("disconnect event did not set input flag");
  read_clear_a: assert property (
    status_read_s ##0 set_vec == 4'h0 |=> flags == 4'h0
  ) else $error("status read did not clear flags");
  eoc_entry_a: assert property (
    $rose(at_end_of_charge) && irq_enable[EN_EOC_IN] |=> flags[FLAG_CHG]
  ) else $error("end-of-charge entry not flagged");
  eoc_exit_a: assert property (
    $fell(at_end_of_charge) && irq_enable[EN_EOC_OUT] |=> flags[FLAG_CHG]
  ) else $error("end-of-charge exit not flagged");
  temp_leave_a: assert property (
    $fell(battery_temp_ok) && irq_enable[EN_TEMP_LEAVE]
    |=> flags[FLAG_TEMP]
  ) else $error("temperature leave not flagged");
  temp_return_a: assert property (
    $rose(battery_temp_ok) && irq_enable[EN_TEMP_RET] |=> flags[FLAG_TEMP]
  ) else $error("temperature return not flagged");
  precond_expiry_a: assert property (
    pre_expire && irq_enable[EN_PRECOND]
    |=> flags[FLAG_TIMER] && timeout_occurred
  ) else $error("precondition expiry not flagged");
  total_expiry_a: assert property (
    tot_expire && irq_enable[EN_TOTAL] |=> flags[FLAG_TIMER] ##1 charge_timeout
  ) else $error("total expiry not flagged");
  precond_bound_a: assert property (
    pre_run |-> pre_cnt < pre_limit(pre_sel)
  ) else $error("precondition count passed its period");
  ovp_hold_a: assert property (
    ovp_seen_s |-> !charge_enable
  ) else $error("charging not held off after overvoltage");
  irq_or_a: assert property (
    (flags != 4'h0) |=> (flags == 4'h0) || !interrupt_request_n
  ) else $error("interrupt output not driven by flags");

endmodule : charger_event_status_logic

// ===== i2c_master_model.sv
`timescale 1ns/1ps
// System processor on the serial port; 160 ns bit period
module i2c_master_model (
  // Serial pins, open drain with pull-up on the wire
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda_line
);
  // Idle bus: clock high, data released to the pull-up
  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // Data moves only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    #80 scl = 1'b1;
    #40 r = sda_line;
    #40 scl = 1'b0;
  endtask : bit_io

  // Byte MSB first, then the acknowledge slot; 8'hFF releases for reads
  task automatic byte_io(input logic [7:0] tx, input logic ack_in,
                         output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(ack_in, ack);
  endtask : byte_io

  // Also used as repeated start; waits for the slave to let go first
  task automatic start;
    sda_low = 1'b0;
    #80 scl = 1'b1;
    #80 sda_low = 1'b1;
    #80 scl = 1'b0;
  endtask : start

  task automatic stop;
    sda_low = 1'b1;
    #80 scl = 1'b1;
    #80 sda_low = 1'b0;
    #80;
  endtask : stop

  // Register write; ok high when all three bytes were acknowledged
  task automatic wr(input logic [7:0] a, d, output logic ok);
    logic [7:0] rx;
    logic       k1, k2, k3;
    start;
    byte_io(8'h54, 1'b1, rx, k1);
    byte_io(a, 1'b1, rx, k2);
    byte_io(d, 1'b1, rx, k3);
    stop;
    ok = !(k1 | k2 | k3);
  endtask : wr

  // Register read: pointer write, repeated start, one byte, then NACK
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] rx;
    logic       k;
    start;
    byte_io(8'h54, 1'b1, rx, k);
    byte_io(a, 1'b1, rx, k);
    start;
    byte_io(8'h55, 1'b1, rx, k);
    byte_io(8'hFF, 1'b1, d, k);
    stop;
  endtask : rd
endmodule : i2c_master_model

// ===== tb_charger_event_status_logic.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  err_total++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_charger_event_status_logic;
  import charger_event_pkg::*;
  logic clock = 1'b0, reset = 1'b1, scl, sda_low, sda_out, sda_oe;
  logic supply_above_uvlo = 1'b0, supply_over_ovp = 1'b0;
  logic supply_below_resume = 1'b1, adapter_sense_input = 1'b1;
  logic battery_temp_in_range = 1'b1, thermal_reg_active = 1'b0;
  logic [1:0] charge_phase = 2'h3, overvoltage_level_sel;
  logic [4:0] charge_current_frac = 5'h10;
  logic interrupt_request_n, charge_enable, charge_timeout, ok;
  logic [7:0] rdv;
  int err_total = 0, num_checks = 0;
  wire sda_line = !(sda_low | sda_oe);  // Pull-up wins when released

  always #4 clock = ~clock;

  charger_event_status_logic #(.TICK_CYCLES(2)) u_charger_event_status_logic
    (.clock, .reset, .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe,
     .supply_above_uvlo, .supply_over_ovp, .supply_below_resume,
     .adapter_sense_input, .battery_temp_in_range, .thermal_reg_active,
     .charge_phase, .charge_current_frac, .interrupt_request_n,
     .charge_enable, .overvoltage_level_sel, .charge_timeout);
  i2c_master_model u_i2c_master_model (.scl, .sda_low, .sda_line);

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step
  task automatic rchk(input logic [7:0] a, e);
    u_i2c_master_model.rd(a, rdv);
    `CHK("register", e, rdv)
  endtask : rchk
  task automatic wr(input logic [7:0] a, d);
    u_i2c_master_model.wr(a, d, ok);
    `CHK("write ack", 1'b1, ok)
  endtask : wr
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // Idle values; no flag may rise while every enable is clear
  task automatic t_reset;
    `CHK("irq_n", 1'b1, interrupt_request_n)
    rchk(IRQ_EN_ADDR, 8'h00);
    rchk(STATUS_ADDR, 8'h04);
    rchk(STATE_INFO_ADDR, 8'h32);
    rchk(8'h7C, 8'h00);
  endtask : t_reset
  task automatic t_input;
    wr(IRQ_EN_ADDR, 8'h22);
    supply_above_uvlo = 1'b1;
    step(10);
    `CHK("irq_n", 1'b0, interrupt_request_n)
    rchk(STATUS_ADDR, 8'h26);
    `CHK("irq_n", 1'b1, interrupt_request_n)
    rchk(STATUS_ADDR, 8'h06);
    supply_above_uvlo = 1'b0;
    step(10);
    rchk(STATUS_ADDR, 8'h24);
  endtask : t_input
  task automatic t_charge;
    wr(IRQ_EN_ADDR, 8'h55);
    charge_phase = PHASE_EOC;
    step(10);
    rchk(STATE_INFO_ADDR, 8'h22);
    rchk(STATUS_ADDR, 8'h15);
    charge_phase = PHASE_FAST;
    battery_temp_in_range = 1'b0;
    adapter_sense_input = 1'b0;
    step(10);
    rchk(STATUS_ADDR, 8'h50);
    rchk(STATE_INFO_ADDR, 8'h10);
    battery_temp_in_range = 1'b1;
    step(10);
    rchk(STATUS_ADDR, 8'h44);
  endtask : t_charge
  // Precondition period 2400 units of two cycles; total timer off
  task automatic t_timer;
    wr(TIMER_CFG_ADDR, 8'h3C);
    `CHK("ovp sel", 2'h3, overvoltage_level_sel)
    wr(IRQ_EN_ADDR, 8'h08);
    charge_phase = PHASE_PRECOND;
    supply_above_uvlo = 1'b1;
    step(4700);
    `CHK("timeout", 1'b0, charge_timeout)
    step(200);
    `CHK("timeout", 1'b1, charge_timeout)
    rchk(STATUS_ADDR, 8'h8E);
  endtask : t_timer
  task automatic t_ovp;
    supply_over_ovp = 1'b1;
    supply_below_resume = 1'b0;
    step(8);
    `CHK("charge", 1'b0, charge_enable)
    supply_over_ovp = 1'b0;
    step(20);
    `CHK("charge", 1'b0, charge_enable)
    supply_below_resume = 1'b1;
    step(8);
    `CHK("charge", 1'b1, charge_enable)
  endtask : t_ovp
  // Half current in thermal regulation doubles the 2400-unit period
  task automatic t_stretch;
    charge_phase = PHASE_FAST;
    thermal_reg_active = 1'b1;
    charge_current_frac = 5'h08;
    step(4);
    charge_phase = PHASE_PRECOND;
    step(9500);
    `CHK("timeout", 1'b0, charge_timeout)
    step(200);
    `CHK("timeout", 1'b1, charge_timeout)
    rchk(STATUS_ADDR, 8'h8E);
    rchk(STATUS_ADDR, 8'h0E);
  endtask : t_stretch
  // Total period 10800 units of two cycles; supply drop clears timeout
  task automatic t_total;
    supply_above_uvlo = 1'b0;
    thermal_reg_active = 1'b0;
    charge_current_frac = 5'h10;
    charge_phase = PHASE_FAST;
    wr(TIMER_CFG_ADDR, 8'h13);
    `CHK("ovp sel", 2'h1, overvoltage_level_sel)
    wr(IRQ_EN_ADDR, 8'h80);
    supply_above_uvlo = 1'b1;
    step(21500);
    `CHK("timeout", 1'b0, charge_timeout)
    step(200);
    `CHK("timeout", 1'b1, charge_timeout)
    rchk(STATUS_ADDR, 8'h8E);
  endtask : t_total

  // Main sequence
  initial
  begin
    step(4);
    reset = 1'b0;
    step(4);
    t_reset;
    t_input;
    t_charge;
    t_timer;
    t_ovp;
    t_stretch;
    t_total;
    wrap_up;
  end
  // Watchdog well past the expected run
  initial
  begin
    #700_000;
    err_total++;
    wrap_up;
  end
endmodule : tb_charger_event_status_logic
